/* File: rtl/fifo_consts.svh */
// constants for the offset-programmable fifo core
`ifndef FIFO_CONSTS_SVH
`define FIFO_CONSTS_SVH
`define FIFO_DATA_W 36
`define FIFO_DEPTH_DEFAULT 512
`define PRESET_SMALL 8
`define PRESET_LARGE 64
`define SEL_SERIAL 2'h3
`define SEL_PRESET_LARGE 2'h2
`define SEL_PRESET_SMALL 2'h1
`define SEL_PARALLEL 2'h0
`define PARALLEL_LOADS 2'h2
`endif

/* File: rtl/fifo_pkg.sv */
// types shared by the offset-programmable fifo core
package fifo_pkg;
  typedef enum logic [1:0] {
    MODE_PARALLEL = 2'b00,
    MODE_PRESET_SMALL = 2'b01,
    MODE_PRESET_LARGE = 2'b10,
    MODE_SERIAL = 2'b11
  } mode_type;

  typedef enum logic [1:0] {
    ST_RESET = 2'b00,
    ST_WAIT = 2'b01,
    ST_SERIAL = 2'b10,
    ST_RUN = 2'b11
  } init_state_type;

  // write port control: select_n, dir (1 = write), enable, mail_select
  typedef struct packed {
    logic select_n;
    logic dir;
    logic enable;
    logic mail_select;
  } write_ctrl_type;

  // read port control: select_n, dir (1 = read), enable, mail_select
  typedef struct packed {
    logic select_n;
    logic dir;
    logic enable;
    logic mail_select;
  } read_ctrl_type;
endpackage : fifo_pkg

/* File: rtl/dual_clock_fifo_offset_prog.sv */
// fifo core with almost-empty / almost-full offset programming
// Notes on behaviour
// - at reset release the two select inputs choose offset programming mode
// - preset modes load 8 or 64 into both offsets, ready after two edges
// - parallel mode raises input-ready two edges after reset completes
// - first two qualified writes load almost-full then almost-empty offset
// - parallel load uses low data bits, width set by depth, msb highest
// - serial mode shifts one data bit per edge while enable input is low
// - serial load is twice offset width, almost-full msb first
// - input-ready stays low until serial load ends, rises next edge
// - write-port data drives only when select and dir are both low
// - fifo write needs select and mail low, dir enable ready high
// - read-port data drives only when select low and dir high
// - fifo read needs select and mail low, dir enable ready high
// - writes and reads proceed in the same cycle independently
// - empty output register fills itself; otherwise only on a qualified read
// - each flag sees the far pointer through two flip-flop stages
// - with output-ready low reads are ignored; the output register holds until a stored word reaches it
// - read pointer advances on every word moved to the output register
// - written word reaches output register on third edge after the write
// - write pointer advances per stored word; full blocks and ignores writes
// - freed location raises input-ready on the third edge after the read
// - reset held one edge clears pointers and both ready flags
`timescale 1ns/1ps
`include "fifo_consts.svh"

module dual_clock_fifo_offset_prog #(
  parameter int DEPTH = `FIFO_DEPTH_DEFAULT
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic select_hi_serial_enable,
  input wire logic select_lo_serial_data,
  input wire fifo_pkg::write_ctrl_type write_port_ctrl,
  input wire logic [`FIFO_DATA_W-1:0] write_port_data_in,
  output logic [`FIFO_DATA_W-1:0] write_port_data_out,
  output logic write_port_data_oe,
  input wire fifo_pkg::read_ctrl_type read_port_ctrl,
  output logic [`FIFO_DATA_W-1:0] read_port_data_out,
  output logic read_port_data_oe,
  output logic input_ready,
  output logic output_ready,
  output logic [$clog2(DEPTH)-1:0] almost_empty_offset,
  output logic [$clog2(DEPTH)-1:0] almost_full_offset
);
  import fifo_pkg::*;

  localparam int AW = $clog2(DEPTH);
  localparam int OW = AW;
  localparam int SBITS = 2 * OW;
  localparam logic [4:0] SBITS_C = 5'(SBITS);
  localparam logic [OW-1:0] PRE_S = OW'(`PRESET_SMALL);
  localparam logic [OW-1:0] PRE_L = OW'(`PRESET_LARGE);

  logic [`FIFO_DATA_W-1:0] mem [DEPTH];

  init_state_type state_q;
  init_state_type state_d;
  mode_type mode_q;
  logic [AW:0] wptr_q;
  logic [AW:0] wptr_d;
  logic [AW:0] rptr_q;
  logic [AW:0] rptr_d;
  // far-pointer copies: two stages each way
  logic [AW:0] wptr_far;
  logic [AW:0] rptr_far;
  logic ir_q;
  logic ir_d;
  logic or_q;
  logic or_d;
  logic [1:0] pload_q;
  logic [4:0] scnt_q;
  logic [SBITS-1:0] sreg_q;
  logic [OW-1:0] ae_off_q;
  logic [OW-1:0] af_off_q;
  logic [`FIFO_DATA_W-1:0] bdata_q;
  logic [`FIFO_DATA_W-1:0] aout_q;
  logic aoe_q;
  logic boe_q;

  wire release_edge;
  wire [1:0] sel_in;
  wire wr_req;
  wire rd_req;
  wire cfg_done;
  wire pload_hit;
  wire store;
  wire nonempty;
  wire load_out;
  wire free;
  wire serial_shift;
  wire serial_full;
  wire [AW:0] fill;

  assign release_edge = (state_q == ST_RESET) && nrst;
  assign sel_in = {select_hi_serial_enable, select_lo_serial_data};

  // qualified requests; enable low makes select and dir don't-care
  assign wr_req = !write_port_ctrl.select_n && !write_port_ctrl.mail_select
    && write_port_ctrl.dir && write_port_ctrl.enable && ir_q;
  assign rd_req = !read_port_ctrl.select_n && !read_port_ctrl.mail_select
    && read_port_ctrl.dir && read_port_ctrl.enable && or_q;

  assign cfg_done = (mode_q != MODE_PARALLEL) || (pload_q == `PARALLEL_LOADS);
  assign pload_hit = wr_req && !cfg_done;
  assign store = wr_req && cfg_done;
  assign wptr_d = store ? wptr_q + 1'b1 : wptr_q;

  // output side compares against the twice-delayed write pointer
  assign nonempty = (rptr_q != wptr_far);
  assign load_out = nonempty && (!or_q || rd_req);
  assign rptr_d = load_out ? rptr_q + 1'b1 : rptr_q;

  // input side: full when DEPTH words sit between the pointers
  assign fill = wptr_d - rptr_far;
  assign free = !fill[AW];

  assign serial_shift = (state_q == ST_SERIAL) && !select_hi_serial_enable
    && (scnt_q != SBITS_C);
  assign serial_full = (scnt_q == SBITS_C);

  always_comb
  begin
    state_d = state_q;
    unique case (state_q)
      ST_RESET:
        state_d = (sel_in == `SEL_SERIAL) ? ST_SERIAL : ST_WAIT;
      ST_WAIT:
        state_d = ST_RUN;
      ST_SERIAL:
        state_d = serial_full ? ST_RUN : ST_SERIAL;
      ST_RUN:
        state_d = ST_RUN;
    endcase
  end

  assign ir_d = (state_d == ST_RUN) && free;
  assign or_d = load_out ? 1'b1 : (rd_req ? 1'b0 : or_q);

  // mode is captured once, on the first edge that sees reset released
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      state_q <= ST_RESET;
      mode_q <= MODE_PARALLEL;
    end
    else
    begin
      state_q <= state_d;
      if (release_edge)
      begin
        mode_q <= mode_type'(sel_in);
      end
    end
  end

  // both pointers move on the same edge without waiting on each other
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      wptr_q <= '0;
      rptr_q <= '0;
    end
    else
    begin
      wptr_q <= wptr_d;
      rptr_q <= rptr_d;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      ir_q <= 1'b0;
      or_q <= 1'b0;
    end
    else
    begin
      ir_q <= ir_d;
      or_q <= or_d;
    end
  end

  // each flag sees the other port's pointer two edges late
  ptr_delay #(
    .W(AW + 1)
  ) wptr_delay (
    .clk(clk),
    .nrst(nrst),
    .ptr_in(wptr_q),
    .ptr_out(wptr_far)
  );

  ptr_delay #(
    .W(AW + 1)
  ) rptr_delay (
    .clk(clk),
    .nrst(nrst),
    .ptr_in(rptr_q),
    .ptr_out(rptr_far)
  );

  // offset programming: preset, parallel or serial
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      ae_off_q <= '0;
      af_off_q <= '0;
    end
    else
    begin
      if (release_edge && sel_in == `SEL_PRESET_SMALL)
      begin
        ae_off_q <= PRE_S;
        af_off_q <= PRE_S;
      end
      else if (release_edge && sel_in == `SEL_PRESET_LARGE)
      begin
        ae_off_q <= PRE_L;
        af_off_q <= PRE_L;
      end
      else if (pload_hit && pload_q == 2'h0)
      begin
        af_off_q <= write_port_data_in[OW-1:0];
      end
      else if (pload_hit)
      begin
        ae_off_q <= write_port_data_in[OW-1:0];
      end
      else if (state_q == ST_SERIAL && serial_full)
      begin
        af_off_q <= sreg_q[SBITS-1:OW];
        ae_off_q <= sreg_q[OW-1:0];
      end
    end
  end

  // counts offset writes; stops at two so later writes reach memory
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      pload_q <= 2'h0;
    end
    else if (pload_hit)
    begin
      pload_q <= pload_q + 2'h1;
    end
  end

  // bits past the full count are dropped, the shifter freezes
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      scnt_q <= 5'h00;
      sreg_q <= '0;
    end
    else if (serial_shift)
    begin
      sreg_q <= {sreg_q[SBITS-2:0], select_lo_serial_data};
      scnt_q <= scnt_q + 5'h01;
    end
  end

  // memory and output register; memory needs no reset
  always_ff @(posedge clk)
  begin
    if (store)
    begin
      mem[wptr_q[AW-1:0]] <= write_port_data_in;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      bdata_q <= '0;
    end
    else if (load_out)
    begin
      bdata_q <= mem[rptr_q[AW-1:0]];
    end
  end

  // enables are registered, so they follow the selects one cycle late
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      aoe_q <= 1'b0;
      boe_q <= 1'b0;
      // the mail path is not built, so this flop only ever holds zero
      aout_q <= '0;
    end
    else
    begin
      aoe_q <= !write_port_ctrl.select_n && !write_port_ctrl.dir;
      boe_q <= !read_port_ctrl.select_n && read_port_ctrl.dir;
    end
  end

  // no mailbox here: the write port has nothing to return but zeros
  assign write_port_data_out = aout_q;
  assign write_port_data_oe = aoe_q;
  assign read_port_data_out = bdata_q;
  assign read_port_data_oe = boe_q;
  assign input_ready = ir_q;
  assign output_ready = or_q;
  assign almost_empty_offset = ae_off_q;
  assign almost_full_offset = af_off_q;
endmodule : dual_clock_fifo_offset_prog

// two-stage delay line for a pointer read by the other port's flag logic
module ptr_delay #(
  parameter int W = 10
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [W-1:0] ptr_in,
  output logic [W-1:0] ptr_out
);
  import fifo_pkg::*;

  logic [W-1:0] stage1_q;
  logic [W-1:0] stage2_q;

  // only the second stage is read outside; the first may be mid-update
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      stage1_q <= '0;
      stage2_q <= '0;
    end
    else
    begin
      stage1_q <= ptr_in;
      stage2_q <= stage1_q;
    end
  end

  assign ptr_out = stage2_q;
endmodule : ptr_delay

/* File: tb/fifo_core_chk_sva.sv */
// assertions on the ports of the offset-programmable fifo core
`timescale 1ns/1ps
module fifo_core_chk #(
  parameter int DEPTH = 512
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic select_hi_serial_enable,
  input wire logic select_lo_serial_data,
  input wire fifo_pkg::write_ctrl_type write_port_ctrl,
  input wire fifo_pkg::read_ctrl_type read_port_ctrl,
  input wire logic [35:0] read_port_data_out,
  input wire logic [35:0] write_port_data_out,
  input wire logic write_port_data_oe,
  input wire logic read_port_data_oe,
  input wire logic input_ready,
  input wire logic output_ready,
  input wire logic [$clog2(DEPTH)-1:0] almost_empty_offset
);
  import fifo_pkg::*;
  default clocking @(posedge clk);
  endclocking
  default disable iff (!nrst);
  wire wdrv = !write_port_ctrl.select_n && !write_port_ctrl.dir;
  wire rdrv = !read_port_ctrl.select_n && read_port_ctrl.dir;
  wire wgo = write_port_ctrl == 4'h6 && input_ready;
  wire rgo = read_port_ctrl == 4'h6 && output_ready;
  wire serial = select_hi_serial_enable && select_lo_serial_data;
  wire preset = select_hi_serial_enable ^ select_lo_serial_data;
  sequence ready_ramp_s;
    !input_ready ##1 input_ready;
  endsequence
  sequence idle_out_s;
    !output_ready ##1 !output_ready;
  endsequence
  chk_wr_oe:
    assert property ($past(nrst) |=> write_port_data_oe == $past(wdrv))
    else $error("write data enable wrong");
  chk_rd_oe:
    assert property ($past(nrst) |=> read_port_data_oe == $past(rdrv))
    else $error("read data enable wrong");
  chk_wr_quiet:
    assert property (write_port_data_oe |-> write_port_data_out == 36'h0)
    else $error("write port data not zero");
  chk_rst_flags:
    assert property ($rose(nrst) |-> !input_ready && !output_ready)
    else $error("ready flag up at reset release");
  chk_ready_ramp:
    assert property ($rose(nrst) && !serial |-> ##1 ready_ramp_s)
    else $error("input ready timing wrong");
  chk_preset_load:
    assert property ($rose(nrst) && preset |=> almost_empty_offset ==
      ($past(select_lo_serial_data) ? 8 : 64))
    else $error("preset offset wrong");
  chk_out_hold:
    assert property (idle_out_s |-> $stable(read_port_data_out))
    else $error("output word changed while not ready");
  chk_out_stand:
    assert property (output_ready && !rgo |=>
      output_ready && $stable(read_port_data_out))
    else $error("output word moved without a read");
  chk_word_land:
    assert property ($rose(output_ready) |-> $past(wgo, 4))
    else $error("output ready rose off the write timing");
endmodule : fifo_core_chk
bind dual_clock_fifo_offset_prog fifo_core_chk #(.DEPTH(DEPTH)) chk (
  .clk, .nrst, .select_hi_serial_enable, .select_lo_serial_data,
  .write_port_ctrl, .read_port_ctrl, .read_port_data_out, .write_port_data_out,
  .write_port_data_oe,
  .read_port_data_oe, .input_ready, .output_ready, .almost_empty_offset);

/* File: tb/fifo_reader.sv */
// far-side reader model: drains the read port with random stalls
`timescale 1ns/1ps
module fifo_reader (
  input wire logic clk,
  input wire logic go,
  output fifo_pkg::read_ctrl_type ctrl
);
  import fifo_pkg::*;
  logic [31:0] seed = 32'h2a45;
  logic [31:0] r;
  initial ctrl = 4'h8;
  always @(posedge clk)
  begin
    r = $random(seed);
    // while idle, select and direction wander since enable stays low
    ctrl <= {~go & r[1], go | r[2], go & r[0], 1'b0};
  end
endmodule : fifo_reader

/* File: tb/dual_clock_fifo_offset_prog_bench.sv */
// self-checking bench for the offset-programmable fifo core
`timescale 1ns/1ps
module dual_clock_fifo_offset_prog_bench;
  import fifo_pkg::*;
  logic clk = 1'b0, nrst = 1'b0, sen = 1'b0, sdat = 1'b0, go = 1'b0;
  write_ctrl_type wc = 4'h8;
  read_ctrl_type rc;
  logic [35:0] wd = 36'h0, rdo;
  logic ir, orr;
  logic [8:0] aeo, afo;
  logic [17:0] bits;
  logic [35:0] exp_q[$];
  int failures, checked, n, k;
  logic [31:0] seed = 32'h2a45;
  dual_clock_fifo_offset_prog #(.DEPTH(512)) dut (.clk(clk), .nrst(nrst),
    .select_hi_serial_enable(sen), .select_lo_serial_data(sdat),
    .write_port_ctrl(wc), .write_port_data_in(wd), .write_port_data_out(),
    .write_port_data_oe(), .read_port_ctrl(rc), .read_port_data_out(rdo),
    .read_port_data_oe(), .input_ready(ir), .output_ready(orr),
    .almost_empty_offset(aeo), .almost_full_offset(afo));
  fifo_reader far (.clk(clk), .go(go), .ctrl(rc));
  initial
    forever #2 clk = ~clk;
  task automatic bad(input string m);
    failures++;
    $display("[ERR] %0t %s", $time, m);
  endtask : bad
  task automatic cmp(input logic [35:0] got, input logic [35:0] want);
    checked++;
    if (got !== want) bad("value mismatch");
  endtask : cmp
  task automatic end_of_test;
    if (failures == 0 && checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : end_of_test
  task automatic restart(input logic [1:0] sel);
    nrst <= 1'b0;
    {sen, sdat} <= sel;
    wc <= 4'h8;
    go <= 1'b0;
    repeat (20) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
  endtask : restart
  task automatic wr(input logic [35:0] d, input bit mem);
    wc <= 4'h6;
    wd <= d;
    n = 0;
    do
      @(posedge clk);
    while (ir !== 1'b1 && ++n < 2000);
    if (ir !== 1'b1)
    begin
      bad("write never taken");
      end_of_test;
    end
    if (mem)
      exp_q.push_back(d);
  endtask : wr
  always @(posedge clk)
    if (nrst && orr === 1'b1 && rc === 4'h6)
    begin
      checked++;
      if (exp_q.size() == 0 || rdo !== exp_q.pop_front())
        bad("read word wrong");
    end
  initial
  begin
    for (int m = 1; m < 3; m++)
    begin
      restart(2'(m));
      #1;
      cmp(afo, m == 1 ? 9'h8 : 9'h40);
    end
    restart(2'h3);
    bits = ($random(seed) & 18'h1feff) | 18'h201;
    for (int i = 17; i >= 0; i--)
    begin
      if (i == 0) cmp(ir, 36'h0);
      sen <= 1'b0;
      sdat <= bits[i];
      @(posedge clk);
      // an edge with enable high in between must not shift
      sen <= 1'b1;
      sdat <= ~sdat;
      @(posedge clk);
    end
    #1;
    cmp(ir, 36'h1);
    cmp({afo, aeo}, bits);
    restart(2'h0);
    wr(36'hfff0001f0, 1'b0);
    wr(36'habc00000d, 1'b0);
    wd <= {$random(seed), 4'h5};
    k = 0;
    for (int i = 0; i < 540; i++)
    begin
      @(posedge clk);
      if (ir === 1'b1)
      begin
        exp_q.push_back(wd);
        wd <= {$random(seed), 4'h5};
        k++;
      end
    end
    cmp(k, 36'h201);
    cmp({afo, aeo}, 18'h3e00d);
    go <= 1'b1;
    for (int i = 0; i < 40; i++)
      wr({$random(seed), 4'h3}, 1'b1);
    wc <= 4'h7;
    @(posedge clk);
    wc <= 4'h0;
    n = 0;
    while (exp_q.size() != 0 && n++ < 9000)
      @(posedge clk);
    cmp(exp_q.size(), 36'h0);
    end_of_test;
  end
endmodule : dual_clock_fifo_offset_prog_bench
